// ==== rtl/ctrl_io_pkg.sv ====
/*
  Shared constants of the discrete control and status port: input and
  output bit positions, instrument state codes and timing counts.
  Assumes the system clock on the Clock setting, 40 MHz.
*/
package ctrl_io_pkg;

  // clock and timing figures, each in its own unit
  localparam int unsigned CLK_HZ        = 40_000_000;
  localparam int unsigned NULL_HOLD_MS  = 3000;   // null cancelled when held longer
  localparam int unsigned PWRUP_MS      = 1000;   // all outputs active after power-on
  localparam int unsigned DEBOUNCE_US   = 1000;   // input must be stable this long
  localparam int unsigned NULL_HOLD_CYC = NULL_HOLD_MS * (CLK_HZ / 1000);
  localparam int unsigned PWRUP_CYC     = PWRUP_MS * (CLK_HZ / 1000);
  localparam int unsigned DEBOUNCE_CYC  = DEBOUNCE_US * (CLK_HZ / 1_000_000);

  // discrete_inputs bit positions
  localparam int unsigned IN_RUN   = 0;
  localparam int unsigned IN_VENT  = 1;
  localparam int unsigned IN_NULL  = 2;
  localparam int unsigned IN_CAL   = 3;
  localparam int unsigned IN_PSEL  = 4;
  localparam int unsigned IN_FILL  = 6;
  localparam int unsigned NUM_IN   = 8;

  // discrete_outputs bit positions
  localparam int unsigned OUT_READY  = 0;
  localparam int unsigned OUT_MEAS   = 1;
  localparam int unsigned OUT_LEAK   = 2;
  localparam int unsigned OUT_ERROR  = 3;
  localparam int unsigned OUT_CALACK = 4;
  localparam int unsigned OUT_FILL   = 5;
  localparam int unsigned OUT_BYPASS = 6;
  localparam int unsigned OUT_LEAK2  = 7;
  localparam int unsigned NUM_OUT    = 8;
  localparam logic [7:0]  OUT_ALL_ON = 8'hff;  // reset and power-up lamp pattern

  // instrument state codes reported by the core
  localparam logic [2:0] ST_READY = 3'h0;
  localparam logic [2:0] ST_EVAC  = 3'h1;
  localparam logic [2:0] ST_ULTRA = 3'h2;
  localparam logic [2:0] ST_FINE  = 3'h3;
  localparam logic [2:0] ST_GROSS = 3'h4;
  localparam logic [2:0] ST_ERROR = 3'h5;

  // leak clears below nine tenths of the limit
  localparam int unsigned HYST_NUM = 9;
  localparam int unsigned HYST_DEN = 10;

endpackage

// ==== rtl/cond_if.sv ====
/*
  Carrier between the input conditioner and the port logic: debounced
  levels and one-cycle edge pulses. Assumes one clock for both ends.
*/
`timescale 1ns/1ps
interface cond_if #(parameter int unsigned N = 8);
  logic [N-1:0] level;
  logic [N-1:0] rise;
  logic [N-1:0] fall;
  modport src (output level, output rise, output fall);
  modport snk (input level, input rise, input fall);
endinterface

// ==== rtl/input_conditioner.sv ====
/*
  Two-stage synchroniser, debounce and edge detection for each discrete
  input. Assumes the pins are asynchronous to sys_clk.
*/
`timescale 1ns/1ps
module input_conditioner #(
  parameter int unsigned N   = 8,
  parameter int unsigned DEB = 40000
) (
  input  wire logic          sys_clk,
  input  wire logic          rst_n,
  input  wire logic [N-1:0]  pins,
  cond_if.src                c
);
  localparam int unsigned CW = $clog2(DEB + 1);

  if (DEB < 1) begin : g_chk
    $error("debounce count must be at least one");
  end

  logic [N-1:0] sync1_q, sync2_q;

  // plain two-flop synchroniser; stage one feeds stage two only
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= pins;
      sync2_q <= sync1_q;
    end
  end

  for (genvar i = 0; i < N; i++) begin : g_bit
    logic [CW-1:0] cnt_q, cnt_d;
    logic          st_q, st_d, rise_q, rise_d, fall_q, fall_d;

    // a change must persist DEB cycles; bounce restarts the count
    always_comb begin
      cnt_d = cnt_q;
      st_d  = st_q;
      if (sync2_q[i] == st_q) begin
        cnt_d = '0;
      end else if (cnt_q == CW'(DEB - 1)) begin
        st_d  = sync2_q[i];
        cnt_d = '0;
      end else begin
        cnt_d = cnt_q + 1'b1;
      end
      rise_d = st_d & ~st_q;  // one pulse per settled low-to-high
      fall_d = ~st_d & st_q;
    end

    always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
        cnt_q  <= '0;
        st_q   <= 1'b0;
        rise_q <= 1'b0;
        fall_q <= 1'b0;
      end else begin
        cnt_q  <= cnt_d;
        st_q   <= st_d;
        rise_q <= rise_d;
        fall_q <= fall_d;
      end
    end

    assign c.level[i] = st_q;
    assign c.rise[i]  = rise_q;
    assign c.fall[i]  = fall_q;

    rise_single_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      rise_q |=> !rise_q) else $error("edge pulse lasted more than one cycle");
    rise_cause_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
      rise_q |-> st_q && !$past(st_q)) else $error("edge pulse without low-to-high change");
  end

endmodule

// ==== rtl/control_io_port.sv ====
/*
  Discrete control and status port: six of the eight conditioned control inputs
  become one-cycle command pulses to the instrument core, and eight
  status outputs report instrument state. Assumes the core's status
  inputs are on sys_clk and the command pulses are consumed there.
*/
`timescale 1ns/1ps
module control_io_port import ctrl_io_pkg::*; #(
  parameter int unsigned NULL_HOLD_CYCLES = NULL_HOLD_CYC,
  parameter int unsigned PWRUP_CYCLES     = PWRUP_CYC,
  parameter int unsigned DEBOUNCE_CYCLES  = DEBOUNCE_CYC,
  parameter int unsigned VAL_W            = 16
) (
  input  wire logic [NUM_IN-1:0]  discrete_inputs,
  input  wire logic               sys_clk,
  input  wire logic               rst_n,
  input  wire logic [2:0]         inst_state,
  input  wire logic               vent_manual,
  input  wire logic               alarm_enable,
  input  wire logic [VAL_W-1:0]   measured_value,
  input  wire logic [VAL_W-1:0]   alarm_limit,
  input  wire logic               cal_waiting,
  input  wire logic               auto_test_mode,
  input  wire logic               background_reached,
  input  wire logic               bypass_open,
  output logic [NUM_OUT-1:0]      discrete_outputs,
  output logic                    meas_start_q,
  output logic                    meas_stop_q,
  output logic                    vent_req_q,
  output logic                    null_req_q,
  output logic                    null_cancel_q,
  output logic                    cal_start_q,
  output logic                    cal_confirm_q,
  output logic                    load_set2_q,
  output logic                    load_set1_q,
  output logic                    fill_done_q
);
  localparam int unsigned HW = $clog2(NULL_HOLD_CYCLES + 1);
  localparam int unsigned PW = $clog2(PWRUP_CYCLES + 1);
  localparam int unsigned XW = VAL_W + 4;

  if (NULL_HOLD_CYCLES < 1 || PWRUP_CYCLES < 1 || VAL_W < 1) begin : g_chk
    $error("timing counts and value width must be at least one");
  end

  typedef enum logic {PH_LAMP, PH_RUN} phase_e;

  cond_if #(.N(NUM_IN)) cin ();

  input_conditioner #(.N(NUM_IN), .DEB(DEBOUNCE_CYCLES)) u_cond (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .pins    (discrete_inputs),
    .c       (cin)
  );

  logic            measuring;
  phase_e          phase_q, phase_d;
  logic [PW-1:0]   pwr_cnt_q, pwr_cnt_d;
  logic [HW-1:0]   hold_q, hold_d;
  logic            leak_q, leak_d;
  logic [NUM_OUT-1:0] out_d;
  logic            start_d, stop_d, vent_d, null_d, cancel_d;
  logic            calst_d, calcf_d, set2_d, set1_d, fill_d;
  logic [XW-1:0]   val_x, lim_x;

  assign measuring = (inst_state == ST_ULTRA) || (inst_state == ST_FINE) || (inst_state == ST_GROSS);
  assign val_x     = XW'(measured_value);
  assign lim_x     = XW'(alarm_limit);

  // command decode from edge pulses; only the null cancel comes from a held level
  always_comb begin
    start_d  = cin.rise[IN_RUN] && (inst_state == ST_READY);
    stop_d   = cin.rise[IN_RUN] && measuring;
    vent_d   = cin.rise[IN_VENT] && vent_manual;
    null_d   = cin.rise[IN_NULL];
    calcf_d  = cin.rise[IN_CAL] && cal_waiting;
    calst_d  = cin.rise[IN_CAL] && !cal_waiting;
    set2_d   = cin.rise[IN_PSEL];
    set1_d   = cin.fall[IN_PSEL];
    fill_d   = cin.rise[IN_FILL];
    // hold timer saturates at NULL_HOLD_CYCLES so the cancel fires once
    hold_d   = hold_q;
    cancel_d = 1'b0;
    if (!cin.level[IN_NULL]) begin
      hold_d = '0;
    end else if (hold_q != HW'(NULL_HOLD_CYCLES)) begin
      hold_d   = hold_q + 1'b1;
      cancel_d = (hold_q == HW'(NULL_HOLD_CYCLES - 1));
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      meas_start_q  <= 1'b0;
      meas_stop_q   <= 1'b0;
      vent_req_q    <= 1'b0;
      null_req_q    <= 1'b0;
      null_cancel_q <= 1'b0;
      cal_start_q   <= 1'b0;
      cal_confirm_q <= 1'b0;
      load_set2_q   <= 1'b0;
      load_set1_q   <= 1'b0;
      fill_done_q   <= 1'b0;
      hold_q        <= '0;
    end else begin
      meas_start_q  <= start_d;
      meas_stop_q   <= stop_d;
      vent_req_q    <= vent_d;
      null_req_q    <= null_d;
      null_cancel_q <= cancel_d;
      cal_start_q   <= calst_d;
      cal_confirm_q <= calcf_d;
      load_set2_q   <= set2_d;
      load_set1_q   <= set1_d;
      fill_done_q   <= fill_d;
      hold_q        <= hold_d;
    end
  end

  // leak hysteresis; widened so 10x value cannot overflow
  always_comb begin
    leak_d = leak_q;
    if (!alarm_enable) begin
      leak_d = 1'b0;
    end else if (val_x > lim_x) begin
      leak_d = 1'b1;
    end else if (XW'(val_x * HYST_DEN) < XW'(lim_x * HYST_NUM)) begin
      leak_d = 1'b0;
    end
  end

  // power-up lamp test then live status; outputs straight from flops
  always_comb begin
    phase_d   = phase_q;
    pwr_cnt_d = pwr_cnt_q;
    case (phase_q)
      PH_LAMP: begin
        if (pwr_cnt_q == PW'(PWRUP_CYCLES - 1)) begin
          phase_d = PH_RUN;
        end else begin
          pwr_cnt_d = pwr_cnt_q + 1'b1;
        end
      end
      default: begin
        phase_d = PH_RUN;  // live status until the next reset
      end
    endcase
    out_d             = OUT_ALL_ON;
    out_d[OUT_READY]  = (inst_state == ST_READY);
    out_d[OUT_MEAS]   = measuring;
    out_d[OUT_LEAK]   = leak_d;
    out_d[OUT_ERROR]  = (inst_state == ST_ERROR);
    out_d[OUT_CALACK] = cal_waiting;
    out_d[OUT_FILL]   = auto_test_mode && background_reached;
    out_d[OUT_BYPASS] = bypass_open;
    out_d[OUT_LEAK2]  = leak_d;  // second leak pin mirrors the alarm
    if (phase_d == PH_LAMP) begin
      out_d = OUT_ALL_ON;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      phase_q          <= PH_LAMP;
      pwr_cnt_q        <= '0;
      leak_q           <= 1'b0;
      discrete_outputs <= OUT_ALL_ON;
    end else begin
      phase_q          <= phase_d;
      pwr_cnt_q        <= pwr_cnt_d;
      leak_q           <= leak_d;
      discrete_outputs <= out_d;
    end
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  run_start_a: assert property (cin.rise[IN_RUN] && inst_state == ST_READY |=> meas_start_q && !meas_stop_q)
    else $error("run edge in ready did not start");
  run_stop_a: assert property (cin.rise[IN_RUN] && measuring |=> meas_stop_q)
    else $error("run edge while measuring did not stop");
  vent_gate_a: assert property (vent_req_q |-> $past(cin.rise[IN_VENT]) && $past(vent_manual))
    else $error("vent request without manual setting");
  null_cancel_a: assert property (null_cancel_q |-> $past(cin.level[IN_NULL]) && hold_q == HW'(NULL_HOLD_CYCLES))
    else $error("null cancel not at hold limit");
  cal_confirm_a: assert property (cin.rise[IN_CAL] && cal_waiting |=> cal_confirm_q && !cal_start_q)
    else $error("calibrate edge did not confirm");
  param_load_a: assert property (cin.fall[IN_PSEL] |=> load_set1_q && !load_set2_q)
    else $error("select release did not load set one");
  lamp_test_a: assert property (phase_q == PH_LAMP |-> discrete_outputs == OUT_ALL_ON)
    else $error("outputs not all on during power-up");
  meas_out_a: assert property (phase_q == PH_RUN && measuring |=> discrete_outputs[OUT_MEAS])
    else $error("measuring output missing");
  leak_hold_a: assert property (leak_q && alarm_enable && val_x <= lim_x && XW'(val_x * HYST_DEN) >= XW'(lim_x * HYST_NUM)
    |=> leak_q)
    else $error("leak cleared inside hysteresis band");
  error_out_a: assert property (phase_q == PH_RUN && inst_state == ST_ERROR |=> discrete_outputs[OUT_ERROR])
    else $error("error output missing");

  cover_start_c: cover property (cin.rise[IN_RUN] ##1 meas_start_q);
  cover_cancel_c: cover property (cin.level[IN_NULL] && hold_q == HW'(NULL_HOLD_CYCLES - 1) ##1 null_cancel_q);
  cover_leak_c: cover property (leak_q ##1 !leak_q);
  cover_lamp_c: cover property (phase_q == PH_LAMP ##1 phase_q == PH_RUN);

endmodule

// ==== verification/plc_model.sv ====
/*
  Controller-side model that drives the eight discrete control pins.
  Assumes pins change only at the falling edge of sys_clk.
*/
`timescale 1ns/1ps
module plc_model import ctrl_io_pkg::*; (
  input  wire logic              sys_clk,
  output logic [NUM_IN-1:0]      discrete_inputs
);
  // passive 24 v inputs read low, so spare pins 5 and 7 stay low
  initial discrete_inputs = 8'h00;

  // one pin change, launched away from the sampling edge
  task automatic drive(input int unsigned idx, input logic lvl);
    @(negedge sys_clk);
    discrete_inputs[idx] = lvl;
  endtask
endmodule

// ==== verification/control_io_port_tb_top.sv ====
/*
  Self-checking bench of the control and status port, with shortened
  counts. Assumes the plc_model file and the design files are compiled first.
*/
`timescale 1ns/1ps
module control_io_port_tb_top import ctrl_io_pkg::*;;
  localparam int unsigned PW = 20;
  typedef struct packed {logic [2:0] idx; logic lvl; logic [2:0] st; logic vm; logic cw;
                         logic [7:0] hold; logic [9:0] exp;} ev_row_s;
  typedef struct packed {logic [2:0] st; logic cw; logic at; logic bg; logic bp; logic [7:0] exp;} st_row_s;
  // events: start,stop,vent,null,cancel,cal,confirm,set2,set1,fill
  localparam ev_row_s EV[25] = '{
    '{3'h0, 1'b1, 3'h0, 1'b0, 1'b0, 8'h0c, 10'h001}, '{3'h0, 1'b1, 3'h0, 1'b0, 1'b0, 8'h0c, 10'h000},
    '{3'h0, 1'b0, 3'h0, 1'b0, 1'b0, 8'h0c, 10'h000}, '{3'h0, 1'b1, 3'h3, 1'b0, 1'b0, 8'h0c, 10'h002},
    '{3'h0, 1'b0, 3'h3, 1'b0, 1'b0, 8'h0c, 10'h000}, '{3'h0, 1'b1, 3'h1, 1'b0, 1'b0, 8'h0c, 10'h000},
    '{3'h0, 1'b0, 3'h1, 1'b0, 1'b0, 8'h0c, 10'h000}, '{3'h1, 1'b1, 3'h0, 1'b0, 1'b0, 8'h0c, 10'h000},
    '{3'h1, 1'b0, 3'h0, 1'b0, 1'b0, 8'h0c, 10'h000}, '{3'h1, 1'b1, 3'h0, 1'b1, 1'b0, 8'h0c, 10'h004},
    '{3'h1, 1'b0, 3'h0, 1'b1, 1'b0, 8'h0c, 10'h000}, '{3'h3, 1'b1, 3'h0, 1'b0, 1'b0, 8'h0c, 10'h020},
    '{3'h3, 1'b0, 3'h0, 1'b0, 1'b0, 8'h0c, 10'h000}, '{3'h3, 1'b1, 3'h0, 1'b0, 1'b1, 8'h0c, 10'h040},
    '{3'h3, 1'b0, 3'h0, 1'b0, 1'b1, 8'h0c, 10'h000}, '{3'h4, 1'b1, 3'h0, 1'b0, 1'b0, 8'h0c, 10'h080},
    '{3'h4, 1'b0, 3'h0, 1'b0, 1'b0, 8'h0c, 10'h100}, '{3'h6, 1'b1, 3'h0, 1'b0, 1'b0, 8'h0c, 10'h200},
    '{3'h6, 1'b0, 3'h0, 1'b0, 1'b0, 8'h0c, 10'h000}, '{3'h2, 1'b1, 3'h0, 1'b0, 1'b0, 8'h0c, 10'h008},
    '{3'h2, 1'b0, 3'h0, 1'b0, 1'b0, 8'h0c, 10'h000}, '{3'h2, 1'b1, 3'h0, 1'b0, 1'b0, 8'h2d, 10'h018},
    '{3'h2, 1'b0, 3'h0, 1'b0, 1'b0, 8'h0c, 10'h000}, '{3'h0, 1'b1, 3'h0, 1'b0, 1'b0, 8'h01, 10'h000},
    '{3'h0, 1'b0, 3'h0, 1'b0, 1'b0, 8'h0c, 10'h000}};
  localparam st_row_s ST[12] = '{
    '{3'h0, 1'b0, 1'b0, 1'b0, 1'b0, 8'h01}, '{3'h1, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00},
    '{3'h2, 1'b0, 1'b0, 1'b0, 1'b0, 8'h02}, '{3'h3, 1'b0, 1'b0, 1'b0, 1'b0, 8'h02},
    '{3'h4, 1'b0, 1'b0, 1'b0, 1'b0, 8'h02}, '{3'h5, 1'b0, 1'b0, 1'b0, 1'b0, 8'h08},
    '{3'h6, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00}, '{3'h1, 1'b1, 1'b0, 1'b0, 1'b0, 8'h10},
    '{3'h1, 1'b0, 1'b1, 1'b1, 1'b0, 8'h20}, '{3'h1, 1'b0, 1'b1, 1'b0, 1'b0, 8'h00},
    '{3'h1, 1'b0, 1'b0, 1'b1, 1'b0, 8'h00}, '{3'h1, 1'b0, 1'b0, 1'b0, 1'b1, 8'h40}};

  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] inst_state = 3'h0;
  logic vent_manual = 1'b0, alarm_enable = 1'b0, cal_waiting = 1'b0;
  logic auto_test_mode = 1'b0, background_reached = 1'b0, bypass_open = 1'b0;
  logic [15:0] measured_value = 16'h0000, alarm_limit = 16'h0064;
  logic [NUM_IN-1:0] pins;
  logic [NUM_OUT-1:0] discrete_outputs;
  logic [9:0] pv, ev_seen = 10'h000, ev_dup = 10'h000;
  logic ev_clr = 1'b0;
  logic p0, p1, p2, p3, p4, p5, p6, p7, p8, p9;
  int mismatches = 0, total_checks = 0;

  always #12.5 sys_clk = ~sys_clk;

  plc_model plc_u (.sys_clk(sys_clk), .discrete_inputs(pins));

  // debounce of 5 so the 3-cycle glitch row stays below it
  control_io_port #(.NULL_HOLD_CYCLES(30), .PWRUP_CYCLES(PW), .DEBOUNCE_CYCLES(5), .VAL_W(16)) dut_u (
    .discrete_inputs(pins), .sys_clk(sys_clk), .rst_n(rst_n), .inst_state(inst_state),
    .vent_manual(vent_manual), .alarm_enable(alarm_enable), .measured_value(measured_value),
    .alarm_limit(alarm_limit), .cal_waiting(cal_waiting), .auto_test_mode(auto_test_mode),
    .background_reached(background_reached), .bypass_open(bypass_open),
    .discrete_outputs(discrete_outputs), .meas_start_q(p0), .meas_stop_q(p1), .vent_req_q(p2),
    .null_req_q(p3), .null_cancel_q(p4), .cal_start_q(p5), .cal_confirm_q(p6), .load_set2_q(p7),
    .load_set1_q(p8), .fill_done_q(p9));

  // gather pulses; a second pulse of one kind is marked as a duplicate
  assign pv = {p9, p8, p7, p6, p5, p4, p3, p2, p1, p0};
  always @(posedge sys_clk) begin
    if (ev_clr) begin
      ev_seen <= 10'h000;
      ev_dup  <= 10'h000;
    end else begin
      ev_dup  <= ev_dup | (ev_seen & pv);
      ev_seen <= ev_seen | pv;
    end
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic close_out();
    if (mismatches == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // reset then power-up phase; outputs must show all lamps before state
  task automatic do_reset();
    @(negedge sys_clk);
    rst_n = 1'b0;
    repeat (2) @(negedge sys_clk);
    check({6'h00, pv}, 16'h0000, "pulse in reset");
    check({8'h00, discrete_outputs}, 16'h00ff, "outputs in reset");
    rst_n = 1'b1;
    repeat (PW / 2) @(negedge sys_clk);
    check({8'h00, discrete_outputs}, 16'h00ff, "power-up lamps");
    repeat (PW) @(negedge sys_clk);
    check({8'h00, discrete_outputs}, {15'h0000, inst_state == 3'h0}, "after power-up");
  endtask

  task automatic leak_step(input logic en, input logic [15:0] val, input logic [7:0] exp);
    @(negedge sys_clk);
    alarm_enable = en;
    measured_value = val;
    repeat (2) @(negedge sys_clk);
    check({8'h00, discrete_outputs}, {8'h00, exp}, "leak lamps");
  endtask

  initial begin
    do_reset();
    foreach (ST[i]) begin
      @(negedge sys_clk);
      {inst_state, cal_waiting, auto_test_mode, background_reached, bypass_open} = ST[i][14:8];
      repeat (2) @(negedge sys_clk);
      check({8'h00, discrete_outputs}, {8'h00, ST[i].exp}, "status row");
    end
    {inst_state, cal_waiting, auto_test_mode, background_reached, bypass_open} = 7'h00;
    foreach (EV[i]) begin
      @(negedge sys_clk);
      {inst_state, vent_manual, cal_waiting} = {EV[i].st, EV[i].vm, EV[i].cw};
      // one rising edge passes inside drive, which empties the pulse log
      ev_clr = 1'b1;
      plc_u.drive(EV[i].idx, EV[i].lvl);
      ev_clr = 1'b0;
      repeat (EV[i].hold) @(negedge sys_clk);
      check({6'h00, ev_seen}, {6'h00, EV[i].exp}, "event row");
      check({6'h00, ev_dup}, 16'h0000, "repeated event");
    end
    // leak hysteresis around a limit of 100, with state evacuating
    inst_state = 3'h1;
    leak_step(1'b1, 16'h0064, 8'h00);
    leak_step(1'b1, 16'h0065, 8'h84);
    leak_step(1'b1, 16'h005a, 8'h84);
    leak_step(1'b1, 16'h0059, 8'h00);
    leak_step(1'b1, 16'h0065, 8'h84);
    leak_step(1'b0, 16'h0065, 8'h00);
    // second reset in mid-run must bring the power-up lamps back
    do_reset();
    close_out();
  end

  // cut a hang well beyond the roughly 490 cycles the run needs
  initial begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    close_out();
  end
endmodule
